// ==== hw/acc_defines.svh ====
// Register offsets, input select codes, reset values and timing counts of the converter control
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
`define ACC_OFS_SC1 8'h00
`define ACC_OFS_SC2 8'h01
`define ACC_OFS_RESH 8'h02
`define ACC_OFS_RESL 8'h03
`define ACC_OFS_CMPH 8'h04
`define ACC_OFS_CMPL 8'h05
`define ACC_OFS_CFG 8'h06
`define ACC_OFS_PINEN 8'h07
`define ACC_OFS_PER 8'h08
`define ACC_SC1_RST 8'h1f
`define ACC_CODE_PIN_LAST 5'h03
`define ACC_CODE_RSV_LO 5'h16
`define ACC_CODE_RSV_HI 5'h19
`define ACC_CODE_TEMP 5'h1a
`define ACC_CODE_BGAP 5'h1b
`define ACC_CODE_VREFH_LO 5'h1c
`define ACC_CODE_VREFL 5'h1e
`define ACC_CODE_OFF 5'h1f
`define ACC_SAMPLE_SHORT 5'h04
`define ACC_SAMPLE_LONG 5'h18
`define ACC_SETTLE_TICKS 2'h3
`define ACC_PER_BASE 4'h5
`define ACC_LF_HZ 32000
`define ACC_CLK_HZ 200000000
`endif

// ==== hw/acc_pkg.sv ====
// Types shared by the converter control block
package acc_pkg;
   typedef enum logic [1:0] {
      ACC_ST_IDLE = 2'b00,
      ACC_ST_WAIT = 2'b01,
      ACC_ST_SAMPLE = 2'b10,
      ACC_ST_STEP = 2'b11
   } acc_state_e;
   typedef enum logic [1:0] {
      ACC_PM_RUN = 2'b00,
      ACC_PM_WAIT = 2'b01,
      ACC_PM_STOP3 = 2'b10,
      ACC_PM_STOPX = 2'b11
   } acc_pmode_e;
   // One-hot source selection towards the analog multiplexer
   typedef struct packed {
      logic [3:0] pin;
      logic gnd;
      logic temp;
      logic bgap;
      logic vrefh;
   } acc_src_s;
   // Register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } acc_bus_s;
endpackage

// ==== hw/acc_ctrl.sv ====
// Converter control: input select decode, clock choice, periodic trigger, SAR sequencer
`timescale 1ns/100ps
`default_nettype none
`include "acc_defines.svh"
module acc_ctrl
   import acc_pkg::*;
#(
   parameter int LF_DIV = `ACC_CLK_HZ / `ACC_LF_HZ,
   parameter int ASYNC_DIV = 100
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Register bus
   input wire acc_bus_s i_bus,
   output logic [7:0] o_rdata,
   // Analog front end
   input wire logic i_cmp_above,
   output logic [9:0] o_dac_code,
   output logic o_sample,
   output logic o_conv_on,
   output logic o_low_power,
   output acc_src_s o_src,
   output logic [3:0] o_pin_analog_en,
   // System context
   input wire logic i_ext_ref_clk,
   input wire acc_pmode_e i_pmode,
   input wire logic i_bandgap_buffer_enable,
   input wire logic i_lowvolt_detect_stop_enable,
   // Events
   output logic o_conv_irq,
   output logic o_cmp_irq
);
   // Tick counters are 16 and 8 bits wide, so larger dividers cannot be served
   if (LF_DIV < 2 || LF_DIV > 65536 || ASYNC_DIV < 1 || ASYNC_DIV > 256) begin : g_bad_div
      $error("acc_ctrl: divider parameters out of range");
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic conv_done_flag_r;
   logic aien_r, adco_r;
   logic [4:0] input_select_code_r;
   logic hw_trig_en_r, cmp_en_r, cmp_ge_r;
   logic [9:0] result_r, cmp_val_r;
   logic low_power_r, long_sample_r, mode10_r;
   logic [1:0] clk_div_r, clk_src_r;
   logic [3:0] pin_enable_reg_r;
   logic per_src_ext_r;
   logic [2:0] periodic_rate_select_r;
   acc_state_e state_r;
   logic [9:0] sar_r;
   logic [3:0] bit_r;
   logic [4:0] cnt_r;
   logic cmp_true_r;

   wire logic wr_sc1 = i_bus.wr && i_bus.addr == `ACC_OFS_SC1;
   wire logic rd_resl = i_bus.rd && i_bus.addr == `ACC_OFS_RESL;
   logic finish;
   logic conversion_trigger_in;

   // Control and configuration writes
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aien_r <= 1'b0;
         adco_r <= 1'b0;
         input_select_code_r <= 5'(`ACC_SC1_RST);
         hw_trig_en_r <= 1'b0;
         cmp_en_r <= 1'b0;
         cmp_ge_r <= 1'b0;
         cmp_val_r <= 10'h000;
         low_power_r <= 1'b0;
         long_sample_r <= 1'b0;
         mode10_r <= 1'b0;
         clk_div_r <= 2'h0;
         clk_src_r <= 2'h0;
         pin_enable_reg_r <= 4'h0;
         per_src_ext_r <= 1'b0;
         periodic_rate_select_r <= 3'h0;
      end else if (i_bus.wr) begin
         unique case (i_bus.addr)
            `ACC_OFS_SC1: begin
               aien_r <= i_bus.wdata[6];
               adco_r <= i_bus.wdata[5];
               input_select_code_r <= i_bus.wdata[4:0];
            end
            `ACC_OFS_SC2: begin
               hw_trig_en_r <= i_bus.wdata[6];
               cmp_en_r <= i_bus.wdata[5];
               cmp_ge_r <= i_bus.wdata[4];
            end
            `ACC_OFS_CMPH: cmp_val_r[9:8] <= i_bus.wdata[1:0];
            `ACC_OFS_CMPL: cmp_val_r[7:0] <= i_bus.wdata;
            `ACC_OFS_CFG: begin
               low_power_r <= i_bus.wdata[7];
               clk_div_r <= i_bus.wdata[6:5];
               long_sample_r <= i_bus.wdata[4];
               mode10_r <= i_bus.wdata[3];
               clk_src_r <= i_bus.wdata[1:0];
            end
            `ACC_OFS_PINEN: pin_enable_reg_r <= i_bus.wdata[3:0];
            `ACC_OFS_PER: begin
               per_src_ext_r <= i_bus.wdata[4];
               periodic_rate_select_r <= i_bus.wdata[2:0];
            end
            default: ;
         endcase
      end
   end

   // Done flag: completion wins over a same-cycle low byte read
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         conv_done_flag_r <= 1'b0;
      end else if (wr_sc1) begin
         conv_done_flag_r <= 1'b0;
      end else if (finish && (!cmp_en_r || cmp_true_r)) begin
         conv_done_flag_r <= 1'b1;
      end else if (rd_resl) begin
         conv_done_flag_r <= 1'b0;
      end
   end

   // Read data stand one cycle after the strobe
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 8'h00;
      end else if (i_bus.rd) begin
         unique case (i_bus.addr)
            `ACC_OFS_SC1: o_rdata <= {conv_done_flag_r, aien_r, adco_r, input_select_code_r};
            `ACC_OFS_SC2: o_rdata <= {state_r != ACC_ST_IDLE, hw_trig_en_r, cmp_en_r,
                                      cmp_ge_r, 4'h0};
            `ACC_OFS_RESH: o_rdata <= mode10_r ? {6'h00, result_r[9:8]} : 8'h00;
            `ACC_OFS_RESL: o_rdata <= mode10_r ? result_r[7:0] : result_r[9:2];
            `ACC_OFS_CMPH: o_rdata <= {6'h00, cmp_val_r[9:8]};
            `ACC_OFS_CMPL: o_rdata <= cmp_val_r[7:0];
            `ACC_OFS_CFG: o_rdata <= {low_power_r, clk_div_r, long_sample_r, mode10_r,
                                      1'b0, clk_src_r};
            `ACC_OFS_PINEN: o_rdata <= {4'h0, pin_enable_reg_r};
            `ACC_OFS_PER: o_rdata <= {3'h0, per_src_ext_r, 1'b0, periodic_rate_select_r};
            default: o_rdata <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic cmp_s1_r, cmp_s2_r, ref_s1_r, ref_s2_r, ref_s3_r;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmp_s1_r <= 1'b0;
         cmp_s2_r <= 1'b0;
         ref_s1_r <= 1'b0;
         ref_s2_r <= 1'b0;
         ref_s3_r <= 1'b0;
      end else begin
         cmp_s1_r <= i_cmp_above;
         cmp_s2_r <= cmp_s1_r;
         ref_s1_r <= i_ext_ref_clk;
         ref_s2_r <= ref_s1_r;
         ref_s3_r <= ref_s2_r;
      end
   end

   // ----------------------------------------------------------------
   // Periodic wakeup counter and hardware trigger
   // ----------------------------------------------------------------
   logic [15:0] lf_cnt_r, per_cnt_r;
   logic lf_tick;
   wire logic stop_any = i_pmode == ACC_PM_STOP3 || i_pmode == ACC_PM_STOPX;
   // Internal low-frequency tick keeps running in the third stop mode
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lf_cnt_r <= 16'h0000;
      end else if (lf_tick) begin
         lf_cnt_r <= 16'h0000;
      end else begin
         lf_cnt_r <= lf_cnt_r + 16'h0001;
      end
   end
   assign lf_tick = lf_cnt_r == 16'(LF_DIV - 1);

   // The deepest stop mode (stopx) halts the counter; run, wait and stop3 keep it
   wire logic per_tick = (per_src_ext_r ? (ref_s2_r && !ref_s3_r) : lf_tick)
                         && i_pmode != ACC_PM_STOPX;
   wire logic [15:0] per_last = 16'((17'h00001 << (periodic_rate_select_r + `ACC_PER_BASE)) - 1);
   wire logic per_ovf = per_tick && periodic_rate_select_r != 3'h0 && per_cnt_r == per_last;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         per_cnt_r <= 16'h0000;
      end else if (periodic_rate_select_r == 3'h0 || per_ovf) begin
         per_cnt_r <= 16'h0000;
      end else if (per_tick) begin
         per_cnt_r <= per_cnt_r + 16'h0001;
      end
   end
   assign conversion_trigger_in = hw_trig_en_r && per_ovf;

   // ----------------------------------------------------------------
   // Conversion clock enable
   // ----------------------------------------------------------------
   logic half_r;
   logic [7:0] async_cnt_r;
   logic [2:0] div_cnt_r;
   logic src_tick, conv_tick;
   wire logic async_tick = async_cnt_r == 8'(ASYNC_DIV - 1);
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         half_r <= 1'b0;
         async_cnt_r <= 8'h00;
      end else begin
         half_r <= !half_r;
         async_cnt_r <= async_tick ? 8'h00 : async_cnt_r + 8'h01;
      end
   end
   // Bus clock sources are gated off in stop; only the local clock survives there
   always_comb begin
      unique case (clk_src_r)
         2'h0: src_tick = !stop_any;
         2'h1: src_tick = !stop_any && half_r;
         2'h2: src_tick = 1'b0;
         2'h3: src_tick = async_tick;
      endcase
   end
   // Further division trades speed for power
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_cnt_r <= 3'h0;
      end else if (state_r == ACC_ST_IDLE) begin
         div_cnt_r <= 3'h0;
      end else if (src_tick) begin
         div_cnt_r <= conv_tick ? 3'h0 : div_cnt_r + 3'h1;
      end
   end
   assign conv_tick = src_tick && div_cnt_r == 3'((4'h1 << clk_div_r) - 4'h1);

   // ----------------------------------------------------------------
   // Successive approximation sequencer
   // ----------------------------------------------------------------
   wire logic disabled = input_select_code_r == `ACC_CODE_OFF;
   wire logic may_run = i_pmode != ACC_PM_STOPX &&
                        (i_pmode != ACC_PM_STOP3 || i_lowvolt_detect_stop_enable);
   wire logic [4:0] sample_len = long_sample_r ? `ACC_SAMPLE_LONG : `ACC_SAMPLE_SHORT;
   wire logic [9:0] cmp_res = mode10_r ? sar_r : {2'h0, sar_r[9:2]};
   wire logic [9:0] cmp_ref = mode10_r ? cmp_val_r : {2'h0, cmp_val_r[7:0]};
   wire logic last_step = state_r == ACC_ST_STEP && conv_tick &&
                          cnt_r[1:0] == `ACC_SETTLE_TICKS - 2'h1 && bit_r == 4'h0;
   assign finish = last_step && may_run;

   always_comb begin
      cmp_true_r = cmp_ge_r ? (cmp_res >= cmp_ref) : (cmp_res < cmp_ref);
      if (last_step && !cmp_s2_r) begin
         cmp_true_r = cmp_ge_r ? ({cmp_res[9:1], 1'b0} >= cmp_ref)
                               : ({cmp_res[9:1], 1'b0} < cmp_ref);
         if (!mode10_r) begin
            cmp_true_r = cmp_ge_r ? (cmp_res >= cmp_ref) : (cmp_res < cmp_ref);
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= ACC_ST_IDLE;
         sar_r <= 10'h000;
         bit_r <= 4'h0;
         cnt_r <= 5'h00;
      end else if (wr_sc1) begin
         // A write aborts; a new one starts, or waits for the hardware trigger, unless the converter is switched off
         cnt_r <= 5'h00;
         if (i_bus.wdata[4:0] == `ACC_CODE_OFF) begin
            state_r <= ACC_ST_IDLE;
         end else if (hw_trig_en_r) begin
            state_r <= ACC_ST_WAIT;
         end else begin
            state_r <= ACC_ST_SAMPLE;
         end
      end else if (may_run) begin
         unique case (state_r)
            ACC_ST_IDLE: ;
            ACC_ST_WAIT: begin
               if (conversion_trigger_in && !disabled) begin
                  state_r <= ACC_ST_SAMPLE;
                  cnt_r <= 5'h00;
               end
            end
            ACC_ST_SAMPLE: begin
               if (conv_tick) begin
                  cnt_r <= cnt_r + 5'h01;
                  if (cnt_r == sample_len - 5'h01) begin
                     state_r <= ACC_ST_STEP;
                     sar_r <= 10'h200;
                     bit_r <= 4'h9;
                     cnt_r <= 5'h00;
                  end
               end
            end
            ACC_ST_STEP: begin
               // Wait a few ticks so the synchronised comparator reflects this trial
               if (conv_tick) begin
                  cnt_r <= cnt_r + 5'h01;
                  if (cnt_r[1:0] == `ACC_SETTLE_TICKS - 2'h1) begin
                     cnt_r <= 5'h00;
                     if (!cmp_s2_r) begin
                        sar_r[bit_r] <= 1'b0;
                     end
                     if (bit_r != 4'h0) begin
                        sar_r[bit_r - 4'h1] <= 1'b1;
                        bit_r <= bit_r - 4'h1;
                     end else if (adco_r) begin
                        state_r <= hw_trig_en_r ? ACC_ST_WAIT : ACC_ST_SAMPLE;
                     end else begin
                        state_r <= ACC_ST_IDLE;
                     end
                  end
               end
            end
         endcase
      end
   end

   // Latch the finished code; reserved codes land here too, unchecked
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         result_r <= 10'h000;
      end else if (finish) begin
         result_r <= cmp_s2_r ? sar_r : {sar_r[9:1], 1'b0};
      end
   end

   // ----------------------------------------------------------------
   // Input select decode and analog controls
   // ----------------------------------------------------------------
   always_comb begin
      o_src = '0;
      if (input_select_code_r <= `ACC_CODE_PIN_LAST) begin
         o_src.pin[input_select_code_r[1:0]] = pin_enable_reg_r[input_select_code_r[1:0]];
      end else if (input_select_code_r >= `ACC_CODE_RSV_LO &&
                   input_select_code_r <= `ACC_CODE_RSV_HI) begin
         o_src = '0;
      end else if (input_select_code_r == `ACC_CODE_TEMP) begin
         o_src.temp = 1'b1;
      end else if (input_select_code_r == `ACC_CODE_BGAP) begin
         o_src.bgap = 1'b1;
      end else if (input_select_code_r >= `ACC_CODE_VREFH_LO &&
                   input_select_code_r < `ACC_CODE_VREFL) begin
         o_src.vrefh = 1'b1;
      end else if (!disabled) begin
         o_src.gnd = 1'b1;
      end
   end

   assign o_pin_analog_en = pin_enable_reg_r;
   assign o_dac_code = sar_r;
   assign o_sample = state_r == ACC_ST_SAMPLE;
   assign o_conv_on = (state_r == ACC_ST_SAMPLE || state_r == ACC_ST_STEP) && !disabled;
   assign o_low_power = low_power_r;
   assign o_conv_irq = conv_done_flag_r && aien_r;
   assign o_cmp_irq = conv_done_flag_r && aien_r && cmp_en_r;
   wire logic unused_ok = i_bandgap_buffer_enable;
endmodule
`default_nettype wire

// ==== verification/acc_analog_model.sv ====
// Analog inputs and free-running reference clock seen by the converter control
`timescale 1ns/100ps
`default_nettype none
module acc_analog_model
   import acc_pkg::*;
(
   // Converter side
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [9:0] i_dac_code,
   input wire acc_src_s i_src,
   // Comparator and reference clock
   output logic o_cmp_above,
   output logic o_ext_ref_clk
);
   logic [9:0] vin;
   logic junk_r;
   logic [3:0] div_r;
   // Level of the selected source; pin k sits at 0c3h plus k times 0f0h, sensor at 2b6h
   always_comb begin
      vin = 10'h000;
      for (int k = 0; k < 4; k++) begin
         if (i_src.pin[k]) vin = 10'h0c3 + 10'(k) * 10'h0f0;
      end
      if (i_src.bgap) vin = 10'h17a;
      if (i_src.temp) vin = 10'h2b6;
      if (i_src.vrefh) vin = 10'h3ff;
   end
   // A floating input must not look like a steady level, so it toggles
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         junk_r <= 1'b0;
         div_r <= 4'h0;
      end else begin
         junk_r <= ~junk_r;
         div_r <= div_r + 4'h1;
      end
   end
   assign o_cmp_above = (i_src == '0) ? junk_r : (vin >= i_dac_code);
   assign o_ext_ref_clk = div_r[3];
endmodule
`default_nettype wire

// ==== verification/acc_ctrl_sva.sv ====
// Concurrent checks on the converter control ports
`timescale 1ns/100ps
`default_nettype none
`include "acc_defines.svh"
module acc_ctrl_sva
   import acc_pkg::*;
#(
   parameter int LF_DIV = 4,
   parameter int ASYNC_DIV = 2
) (
   // Watched ports
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire acc_bus_s i_bus,
   input wire logic o_conv_on,
   input wire logic o_sample,
   input wire logic o_low_power,
   input wire logic [9:0] o_dac_code,
   input wire acc_src_s o_src,
   input wire logic [3:0] o_pin_analog_en,
   input wire acc_pmode_e i_pmode,
   input wire logic i_lowvolt_detect_stop_enable,
   input wire logic o_conv_irq,
   input wire logic o_cmp_irq
);
   // ----
   // Shadow of trigger, clock and mode choice
   // ----
   logic hw_r;
   logic co_r;
   logic [1:0] cs_r;
   logic wsc1;
   logic frz;
   assign wsc1 = i_bus.wr && i_bus.addr == `ACC_OFS_SC1;
   // Only software starts have a fixed start moment; the start check keeps to clock source 0 and run mode
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hw_r <= 1'b0;
         co_r <= 1'b0;
         cs_r <= 2'h0;
      end else if (i_bus.wr) begin
         if (i_bus.addr == `ACC_OFS_SC2) hw_r <= i_bus.wdata[6];
         if (i_bus.addr == `ACC_OFS_SC1) co_r <= i_bus.wdata[5];
         if (i_bus.addr == `ACC_OFS_CFG) cs_r <= i_bus.wdata[1:0];
      end
   end
   assign frz = i_pmode == ACC_PM_STOPX ||
                (i_pmode == ACC_PM_STOP3 && !i_lowvolt_detect_stop_enable);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   // ----
   // Properties
   // ----
   a_src_onehot: assert property ($onehot0(o_src))
      else $error("more than one source selected");
   a_pin_gate: assert property (!(|(o_src.pin & ~o_pin_analog_en)))
      else $error("pin routed without its enable");
   a_off_write: assert property (
      wsc1 && i_bus.wdata[4:0] == `ACC_CODE_OFF |=> !o_conv_on && o_src == '0)
      else $error("off code left converter on");
   a_sw_start: assert property (
      wsc1 && i_bus.wdata[4:0] != `ACC_CODE_OFF && !hw_r && cs_r == 2'h0 &&
      i_pmode == ACC_PM_RUN |=> o_sample && !o_conv_irq)
      else $error("control write did not restart");
   a_single_idle: assert property ($rose(o_conv_irq) && !co_r |=> !o_conv_on [*3])
      else $error("single conversion did not go idle");
   a_irq_gate: assert property (o_cmp_irq |-> o_conv_irq)
      else $error("compare event without done");
   a_pin_reg: assert property (
      i_bus.wr && i_bus.addr == `ACC_OFS_PINEN |=> o_pin_analog_en == $past(i_bus.wdata[3:0]))
      else $error("pin enable not written");
   a_low_pwr: assert property (
      i_bus.wr && i_bus.addr == `ACC_OFS_CFG |=> o_low_power == $past(i_bus.wdata[7]))
      else $error("low power bit not written");
   a_stop_hold: assert property (
      frz && $past(frz) && !$past(i_bus.wr) |-> $stable(o_dac_code))
      else $error("sequencer moved in a stop mode");
   c_done: cover property ($rose(o_conv_irq));
   c_cmp: cover property (o_cmp_irq);
   c_stop3: cover property (i_pmode == ACC_PM_STOP3 && $rose(o_conv_irq));
endmodule
bind acc_ctrl acc_ctrl_sva #(.LF_DIV(LF_DIV), .ASYNC_DIV(ASYNC_DIV)) u_sva (
   .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_bus(i_bus), .o_conv_on(o_conv_on),
   .o_sample(o_sample), .o_low_power(o_low_power), .o_dac_code(o_dac_code), .o_src(o_src),
   .o_pin_analog_en(o_pin_analog_en), .i_pmode(i_pmode), .o_conv_irq(o_conv_irq),
   .i_lowvolt_detect_stop_enable(i_lowvolt_detect_stop_enable), .o_cmp_irq(o_cmp_irq)
);
`default_nettype wire

// ==== verification/adc_channel_trigger_config_tb_top.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
`include "acc_defines.svh"
module adc_channel_trigger_config_tb_top
   import acc_pkg::*;
;
   logic i_clk_sys = 1'b0;
   logic i_rst_n = 1'b0;
   acc_bus_s bus = '0;
   acc_pmode_e pm = ACC_PM_RUN;
   logic lvd = 1'b0;
   logic bgb = 1'b0;
   logic cmp, ext, lp, ci, mi, smp, con;
   logic [7:0] rdata, rv;
   logic [9:0] dac;
   logic [3:0] pen;
   acc_src_s src;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   // Conversion table: code, configuration, input level
   logic [4:0] tc [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h00, 5'h1b, 5'h1d, 5'h04, 5'h1a};
   logic [7:0] tf [9] = '{8'h08, 8'h09, 8'h0b, 8'h88, 8'h00, 8'h08, 8'h09, 8'h08, 8'h58};
   logic [9:0] tv [9] = '{10'h0c3, 10'h1b3, 10'h2a3, 10'h393, 10'h0c3, 10'h17a, 10'h3ff,
                          10'h000, 10'h2b6};
   acc_pmode_e tp [6] = '{ACC_PM_RUN, ACC_PM_RUN, ACC_PM_WAIT, ACC_PM_STOP3, ACC_PM_STOP3,
                          ACC_PM_STOPX};
   acc_ctrl #(.LF_DIV(4), .ASYNC_DIV(2)) uut (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata),
      .i_cmp_above(cmp), .o_dac_code(dac), .o_sample(smp), .o_conv_on(con),
      .o_low_power(lp), .o_src(src), .o_pin_analog_en(pen), .i_ext_ref_clk(ext),
      .i_pmode(pm), .i_bandgap_buffer_enable(bgb), .i_lowvolt_detect_stop_enable(lvd),
      .o_conv_irq(ci), .o_cmp_irq(mi)
   );
   acc_analog_model u_ana (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_dac_code(dac), .i_src(src),
      .o_cmp_above(cmp), .o_ext_ref_clk(ext)
   );
   // ----
   // Clock, hang guard and closing report
   // ----
   always #2.5 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         $display("BAD %0t run hung", $time);
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ----
   // Bus cycles and comparisons; every task starts and ends just after an edge
   // ----
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk_sys);
      bus <= '0;
      @(posedge i_clk_sys);
   endtask
   // Read data stand from the cycle after the strobe until the next read
   task automatic rd(input logic [7:0] a);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk_sys);
      bus <= '0;
      #1 rv = rdata;
      @(posedge i_clk_sys);
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %0t value %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %0t flag %b expected %b", $time, g, e);
      end
   endtask
   // Waits a bounded time for the done event
   task automatic wdone(input int n, input logic e);
      logic s;
      s = 1'b0;
      for (int i = 0; i < n && !s; i++) begin
         @(posedge i_clk_sys);
         s = (ci === 1'b1);
      end
      chk1(s, e);
   endtask
   task automatic conv(input logic [4:0] c, input logic [7:0] f, input logic [9:0] v);
      wr(`ACC_OFS_CFG, f);
      wr(`ACC_OFS_SC1, {3'h2, c});
      wdone(400, 1'b1);
      rd(`ACC_OFS_RESH);
      chk8(rv, f[3] ? {6'h00, v[9:8]} : 8'h00);
      rd(`ACC_OFS_RESL);
      chk8(rv, f[3] ? v[7:0] : v[9:2]);
      chk1(ci, 1'b0);
   endtask
   // Source expected with pins 0 and 2 enabled
   function automatic logic [7:0] src_exp(input logic [4:0] c);
      if (c < 5'h04) return (c[0] == 1'b0) ? (8'h10 << c[1:0]) : 8'h00;
      if (c < 5'h16) return 8'h08;
      case (c)
         5'h1a: return 8'h04;
         5'h1b: return 8'h02;
         5'h1c, 5'h1d: return 8'h01;
         5'h1e: return 8'h08;
         default: return 8'h00;
      endcase
   endfunction
   // ----
   // Tests
   // ----
   initial begin
      repeat (12) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      @(posedge i_clk_sys);
      rd(`ACC_OFS_SC1);
      chk8(rv, `ACC_SC1_RST);
      chk8(src, 8'h00);
      rd(8'h09);
      chk8(rv, 8'h00);
      $display("test reset done");
      // Bandgap buffer is set before its conversion
      bgb <= 1'b1;
      wr(`ACC_OFS_PINEN, 8'h0f);
      // Last row is the temperature sensor: long sample on a divided clock
      for (int i = 0; i < 9; i++) conv(tc[i], tf[i], tv[i]);
      $display("test conversions done");
      // Every code: one source or none, and a conversion unless off
      wr(`ACC_OFS_PINEN, 8'h05);
      for (int c = 0; c < 32; c++) begin
         wr(`ACC_OFS_SC1, 8'(c));
         chk8(src, src_exp(5'(c)));
         chk1(con, c != 31);
      end
      $display("test decode done");
      // The alternate clock choice never finishes
      wr(`ACC_OFS_CFG, 8'h0a);
      wr(`ACC_OFS_SC1, 8'h40);
      wdone(300, 1'b0);
      wr(`ACC_OFS_SC1, 8'h1f);
      $display("test alternate clock done");
      // Continuous: a second result comes unasked; the off code stops it and clears done
      wr(`ACC_OFS_CFG, 8'h08);
      wr(`ACC_OFS_SC1, 8'h60);
      wdone(300, 1'b1);
      rd(`ACC_OFS_RESL);
      chk8(rv, 8'hc3);
      wdone(300, 1'b1);
      wr(`ACC_OFS_SC1, 8'h5f);
      chk1(ci, 1'b0);
      chk1(con, 1'b0);
      $display("test continuous done");
      // Compare rows: less-than true and false, greater-or-equal true and false
      wr(`ACC_OFS_CFG, 8'h08);
      wr(`ACC_OFS_CMPH, 8'h00);
      for (int j = 0; j < 4; j++) begin
         wr(`ACC_OFS_SC2, j[1] ? 8'h30 : 8'h20);
         wr(`ACC_OFS_CMPL, (j[0] ^ j[1]) ? 8'hc3 : 8'hc4);
         wr(`ACC_OFS_SC1, 8'h40);
         wdone(300, j == 0 || j == 2);
         chk1(mi, j == 0 || j == 2);
         rd(`ACC_OFS_RESL);
      end
      $display("test compare done");
      // Periodic trigger across sources and power modes
      for (int i = 0; i < 6; i++) begin
         wr(`ACC_OFS_PER, (i == 1) ? 8'h11 : 8'h01);
         wr(`ACC_OFS_SC2, 8'h40);
         wr(`ACC_OFS_CFG, 8'h0b);
         wr(`ACC_OFS_SC1, 8'h40);
         pm <= tp[i];
         lvd <= (i == 3 || i == 5);
         wdone(1500, i < 4);
         pm <= ACC_PM_RUN;
         rd(`ACC_OFS_RESL);
         wr(`ACC_OFS_SC1, 8'h1f);
      end
      $display("test trigger done");
      test_done();
   end
endmodule
`default_nettype wire
